// ---- rtl/tmc_timer3_ctrl.v ----
/*
 * Third timer: control register, clock source selection, 16-bit or split
 * 8-bit auto-reload counting, low-frequency oscillator capture and the
 * interrupt request toward the core.
 * Assumes a simple special function register bus on the system clock with
 * one-cycle read and write strobes; ext_osc_div8, lfo_div8 and lfo_out are
 * asynchronous pin level inputs.
 */
`timescale 1ns/10ps
`include "tmc_defines.vh"

module tmc_timer3_ctrl (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Register bus
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	// Configuration from the core
	input wire timer_irq_enable,
	input wire high_byte_clock_select,
	input wire low_byte_clock_select,
	input wire suspend,
	// Clock sources from pins
	input wire ext_osc_div8,
	input wire lfo_div8,
	input wire lfo_out,
	// Status
	output wire timer_irq,
	output wire [7:0] count_high_byte,
	output wire [7:0] count_low_byte
);

	reg [1:0] rst_sync_q;
	wire rst_sync_b;
	reg [7:0] ctrl_q;
	reg [7:0] reload_low_q;
	reg [7:0] reload_high_q;
	reg [3:0] div12_q;
	reg [1:0] ext_sync_q;
	reg [1:0] lfo8_sync_q;
	reg [1:0] lfo_sync_q;
	reg ext_prev_q;
	reg lfo8_prev_q;
	reg lfo_prev_q;
	reg ext_raw_q;
	reg lfo8_raw_q;
	wire div12_tick;
	wire ext_tick;
	wire lfo8_tick;
	reg alt_tick;
	wire low_tick;
	wire high_tick;
	wire split;
	wire run;
	wire low_en;
	wire high_en;
	wire low_ovf;
	wire high_ovf;
	wire low_reload;
	wire high_reload;
	wire cap_event;
	wire wr_ctrl;

	////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_sync_q[1];

	////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ext_sync_q <= 2'h0;
			lfo8_sync_q <= 2'h0;
			lfo_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
			lfo8_prev_q <= 1'b0;
			lfo_prev_q <= 1'b0;
			ext_raw_q <= 1'b0;
			lfo8_raw_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_osc_div8};
			lfo8_sync_q <= {lfo8_sync_q[0], lfo_div8};
			lfo_sync_q <= {lfo_sync_q[0], lfo_out};
			ext_prev_q <= ext_sync_q[1];
			lfo8_prev_q <= lfo8_sync_q[1];
			lfo_prev_q <= lfo_sync_q[1];
			// Raw copies give a one edge rise detect for the suspend path
			ext_raw_q <= ext_osc_div8;
			lfo8_raw_q <= lfo_div8;
		end
	end

	// Suspend stops the system clock, so the raw divided source edges act directly;
	// one clock design models this as an unsynchronised rising detect on the raw pin
	// Raw edge compared with the raw copy, else one rise would count three times
	assign ext_tick = suspend ? (ext_osc_div8 && !ext_raw_q) : (ext_sync_q[1] && !ext_prev_q);
	assign lfo8_tick = suspend ? (lfo_div8 && !lfo8_raw_q) : (lfo8_sync_q[1] && !lfo8_prev_q);
	assign cap_event = ctrl_q[`TMC_CAP_BIT] && lfo_prev_q && !lfo_sync_q[1];

	////////////////////////////////////////////////////////////////
	// System clock divided by 12
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			div12_q <= 4'h0;
		end else if (div12_tick) begin
			div12_q <= 4'h0;
		end else begin
			div12_q <= div12_q + 4'h1;
		end
	end
	assign div12_tick = (div12_q == (`TMC_SYS_DIV - 4'h1));

	// Alternate source decode, shared by both bytes
	always @* begin
		case (ctrl_q[`TMC_ALT_HI:`TMC_ALT_LO])
			`TMC_ALT_DIV12: alt_tick = div12_tick;
			`TMC_ALT_EXT8: alt_tick = ext_tick;
			`TMC_ALT_LFO8: alt_tick = lfo8_tick;
			default: alt_tick = 1'b0;
		endcase
	end

	// Per byte choice of system clock or alternate source
	assign low_tick = low_byte_clock_select ? 1'b1 : alt_tick;
	assign high_tick = high_byte_clock_select ? 1'b1 : alt_tick;

	////////////////////////////////////////////////////////////////
	// Mode and run gating
	assign split = ctrl_q[`TMC_SPLIT_BIT];
	assign run = ctrl_q[`TMC_RUN_BIT];
	// In 16-bit mode the low byte clock select drives the whole count
	assign low_en = split ? low_tick : (run && low_tick);
	assign high_en = split ? (run && high_tick) : low_ovf;
	// 16-bit reload happens on the full carry; split bytes reload alone
	assign low_reload = split ? low_ovf : (low_ovf && high_ovf);
	assign high_reload = high_ovf;

	wire wr_cntl = sfr_wr && (sfr_addr == `TMC_CNTL_ADDR);
	wire wr_cnth = sfr_wr && (sfr_addr == `TMC_CNTH_ADDR);

	tmc_byte_counter u_low (
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.count_en(low_en),
		.reload_en(low_reload),
		.reload_val(reload_low_q),
		.wr_en(wr_cntl),
		.wr_data(sfr_wdata),
		.count_q(count_low_byte),
		.ovf(low_ovf)
	);

	tmc_byte_counter u_high (
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.count_en(high_en),
		.reload_en(high_reload),
		.reload_val(reload_high_q),
		.wr_en(wr_cnth),
		.wr_data(sfr_wdata),
		.count_q(count_high_byte),
		.ovf(high_ovf)
	);

	////////////////////////////////////////////////////////////////
	// Control register; hardware set beats a software clear
	assign wr_ctrl = sfr_wr && (sfr_addr == `TMC_CTRL_ADDR);
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_q <= `TMC_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= sfr_wdata;
			end
			if (high_ovf || cap_event) begin
				ctrl_q[`TMC_HOVF_BIT] <= 1'b1;
			end
			if (low_ovf) begin
				ctrl_q[`TMC_LOVF_BIT] <= 1'b1;
			end
		end
	end

	// Reload registers; capture overrides a same cycle write
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reload_low_q <= 8'h00;
			reload_high_q <= 8'h00;
		end else if (cap_event) begin
			reload_low_q <= count_low_byte;
			reload_high_q <= count_high_byte;
		end else begin
			if (sfr_wr && (sfr_addr == `TMC_RLL_ADDR)) begin
				reload_low_q <= sfr_wdata;
			end
			if (sfr_wr && (sfr_addr == `TMC_RLH_ADDR)) begin
				reload_high_q <= sfr_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, unmapped addresses read zero
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`TMC_CTRL_ADDR: sfr_rdata <= ctrl_q;
				`TMC_RLL_ADDR: sfr_rdata <= reload_low_q;
				`TMC_RLH_ADDR: sfr_rdata <= reload_high_q;
				`TMC_CNTL_ADDR: sfr_rdata <= count_low_byte;
				`TMC_CNTH_ADDR: sfr_rdata <= count_high_byte;
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	// Level request while an enabled flag stands, as the core expects
	assign timer_irq = timer_irq_enable && (ctrl_q[`TMC_HOVF_BIT] ||
		(ctrl_q[`TMC_LIRQ_BIT] && ctrl_q[`TMC_LOVF_BIT]));

endmodule

// ---- rtl/tmc_defines.vh ----
/*
 * Constants for the third timer control logic: register addresses, field
 * positions, reset value, clock source codes and divider counts.
 * Assumes inclusion by bare name from design files under rtl/.
 */
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// Register addresses on the special function register bus
`define TMC_CTRL_ADDR 8'h91
`define TMC_RLL_ADDR 8'h92
`define TMC_RLH_ADDR 8'h93
`define TMC_CNTL_ADDR 8'h94
`define TMC_CNTH_ADDR 8'h95

// Control register fields
`define TMC_HOVF_BIT 7
`define TMC_LOVF_BIT 6
`define TMC_LIRQ_BIT 5
`define TMC_CAP_BIT 4
`define TMC_SPLIT_BIT 3
`define TMC_RUN_BIT 2
`define TMC_ALT_HI 1
`define TMC_ALT_LO 0
`define TMC_CTRL_RESET 8'h00

// Alternate clock encodings
`define TMC_ALT_DIV12 2'h0
`define TMC_ALT_EXT8 2'h1
`define TMC_ALT_RSVD 2'h2
`define TMC_ALT_LFO8 2'h3

// Divider counts
`define TMC_SYS_DIV 4'hC
`define TMC_SRC_DIV 3'h7

`endif

// ---- rtl/tmc_byte_counter.v ----
/*
 * One 8-bit up counter with auto-reload and overflow pulse.
 * Assumes count enable and load come from logic on the same clock.
 */
`timescale 1ns/10ps

module tmc_byte_counter (
	// Clock and reset
	input wire clock,
	input wire rst_sync_b,
	// Control
	input wire count_en,
	input wire reload_en,
	input wire [7:0] reload_val,
	input wire wr_en,
	input wire [7:0] wr_data,
	// Status
	output reg [7:0] count_q,
	output wire ovf
);

	// Roll over only while counting at 0xFF
	assign ovf = count_en && (count_q == 8'hFF);

	////////////////////////////////////////////////////////////////
	// Counter register, software write has the last word
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			count_q <= 8'h00;
		end else if (wr_en) begin
			count_q <= wr_data;
		end else if (reload_en) begin
			count_q <= reload_val;
		end else if (count_en) begin
			count_q <= count_q + 8'h01;
		end
	end

endmodule

// ---- sim/tmc_timer3_monitor.sv ----
/* Port checker for the third timer control block.
   Assumes binding to tmc_timer3_ctrl on its system clock. */
`timescale 1ns/10ps
module tmc_mon (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Register bus
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	// Interrupt and counts
	input wire timer_irq_enable,
	input wire timer_irq,
	input wire [7:0] count_high_byte,
	input wire [7:0] count_low_byte
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	// Interrupt relations; flags only fall by a write
	a_irq_needs_en: assert property (timer_irq |-> timer_irq_enable) else $error("irq without enable");
	a_irq_sticky: assert property ((timer_irq && !sfr_wr) ##1 timer_irq_enable |-> timer_irq)
		else $error("irq dropped without write");
	a_wrap_irq: assert property ($past(count_high_byte) == 8'hFF && count_high_byte != 8'hFF
		&& !$past(sfr_wr) && timer_irq_enable |-> timer_irq) else $error("high wrap without irq");
	////////////////////////////////////////
	// Counting: steps of one, jumps only at wrap or by a write
	a_low_step: assert property (count_low_byte != $past(count_low_byte) && $past(count_low_byte) != 8'hFF
		&& !$past(sfr_wr) |-> count_low_byte == $past(count_low_byte) + 8'h01) else $error("low byte jumped");
	a_high_step: assert property (count_high_byte != $past(count_high_byte) && $past(count_high_byte) != 8'hFF
		&& !$past(sfr_wr) |-> count_high_byte == $past(count_high_byte) + 8'h01) else $error("high byte jumped");
	a_count_write: assert property (sfr_wr && sfr_addr == 8'h94 |=> count_low_byte == $past(sfr_wdata))
		else $error("count write lost");
	// Read data moves only after a read
	a_rdata_hold: assert property (!$past(sfr_rd) && !$past(sfr_rd, 2) |-> $stable(sfr_rdata))
		else $error("read data moved");
	a_unmapped_rd: assert property (sfr_rd && sfr_addr == 8'h90 |-> ##2 sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	c_irq: cover property (timer_irq);
	c_low_wrap: cover property ($past(count_low_byte) == 8'hFF && count_low_byte != 8'hFF);
	c_ctrl_rd: cover property (sfr_rd && sfr_addr == 8'h91);
endmodule
bind tmc_timer3_ctrl tmc_mon i_tmc_mon (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
	.timer_irq(timer_irq), .count_high_byte(count_high_byte), .count_low_byte(count_low_byte));

// ---- sim/tmc_core_model.sv ----
/* Core side of the register bus: one-cycle write and read strobes.
   Assumes calls at a falling edge of the system clock. */
`timescale 1ns/10ps
module tmc_core_model (
	// Clock
	input wire clock,
	// Register bus
	output reg [7:0] sfr_addr,
	output reg sfr_wr,
	output reg sfr_rd,
	output reg [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata
);
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// Strobe held across one rising edge, then one idle edge so back to back calls never drive it twice at once
	task wr(input [7:0] a, input [7:0] d);
		begin
			sfr_addr = a;
			sfr_wdata = d;
			sfr_wr = 1'b1;
			@(negedge clock);
			sfr_wr = 1'b0;
			sfr_wdata = ~d;
			@(negedge clock);
		end
	endtask
	// Data taken a full cycle later, whichever edge registers it
	task rd(input [7:0] a, output [7:0] d);
		begin
			sfr_addr = a;
			sfr_rd = 1'b1;
			@(negedge clock);
			sfr_rd = 1'b0;
			@(negedge clock);
			d = sfr_rdata;
		end
	endtask
endmodule

// ---- sim/tmc_timer3_ctrl_test.sv ----
/* Self-checking bench for the third timer control block.
   Assumes the core model and the bound port checker. */
`timescale 1ns/10ps
module tmc_timer3_ctrl_test;
	reg clock = 1'b0;
	reg rst_b = 1'b0;
	reg timer_irq_enable = 1'b0;
	reg high_byte_clock_select = 1'b0;
	reg low_byte_clock_select = 1'b0;
	reg suspend = 1'b0;
	reg ext_osc_div8 = 1'b0;
	reg lfo_div8 = 1'b0;
	reg lfo_out = 1'b0;
	wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, count_high_byte, count_low_byte;
	wire sfr_wr, sfr_rd, timer_irq;
	integer errors = 0;
	integer tests_run = 0;
	integer cycles = 0;
	integer n;
	reg [7:0] v;
	tmc_core_model i_tmc_core_model (.clock(clock), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
	tmc_timer3_ctrl i_tmc_timer3_ctrl (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
		.high_byte_clock_select(high_byte_clock_select), .low_byte_clock_select(low_byte_clock_select),
		.suspend(suspend), .ext_osc_div8(ext_osc_div8), .lfo_div8(lfo_div8), .lfo_out(lfo_out),
		.timer_irq(timer_irq), .count_high_byte(count_high_byte), .count_low_byte(count_low_byte));
	////////////////////////////////////////
	// Clock, and a ceiling well above the run length
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			$display("checks %0d errors %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task check(input string name, input [7:0] seen, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task rdc(input [7:0] a, input [7:0] exp);
		begin
			i_tmc_core_model.rd(a, v);
			check("register", v, exp);
		end
	endtask
	task clks(input integer k);
		repeat (k) @(negedge clock);
	endtask
	// Slow pin pulses; long low time covers the synchroniser lag
	task pulse8(input sel, input integer k);
		repeat (k) begin
			if (sel)
				lfo_div8 = 1'b1;
			else
				ext_osc_div8 = 1'b1;
			clks(6);
			lfo_div8 = 1'b0;
			ext_osc_div8 = 1'b0;
			clks(6);
		end
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		clks(3);
		rst_b = 1'b1;
		clks(3);
		rdc(8'h91, 8'h00);
		rdc(8'h90, 8'h00);
		timer_irq_enable = 1'b1;
		low_byte_clock_select = 1'b1;
		i_tmc_core_model.wr(8'h92, 8'h34);
		i_tmc_core_model.wr(8'h93, 8'h12);
		i_tmc_core_model.wr(8'h94, 8'hFE);
		i_tmc_core_model.wr(8'h95, 8'hFF);
		i_tmc_core_model.wr(8'h91, 8'h04);
		for (n = 0; n < 20 && timer_irq !== 1'b1; n = n + 1)
			clks(1);
		check("high byte", count_high_byte, 8'h12);
		clks(20);
		rdc(8'h91, 8'hC4);
		check("irq", {7'h00, timer_irq}, 8'h01);
		i_tmc_core_model.wr(8'h91, 8'h06);
		low_byte_clock_select = 1'b0;
		i_tmc_core_model.wr(8'h94, 8'h55);
		clks(30);
		check("held low", count_low_byte, 8'h55);
		rdc(8'h91, 8'h06);
		i_tmc_core_model.wr(8'h95, 8'hAB);
		i_tmc_core_model.wr(8'h94, 8'hCD);
		i_tmc_core_model.wr(8'h91, 8'h16);
		lfo_out = 1'b1;
		clks(4);
		lfo_out = 1'b0;
		clks(6);
		rdc(8'h92, 8'hCD);
		rdc(8'h93, 8'hAB);
		rdc(8'h91, 8'h96);
		check("capture irq", {7'h00, timer_irq}, 8'h01);
		i_tmc_core_model.wr(8'h91, 8'h04);
		i_tmc_core_model.wr(8'h94, 8'h00);
		// Exactly 120 edges after the write, so any divider phase gives ten ticks
		clks(119);
		check("div12", count_low_byte, 8'h0A);
		i_tmc_core_model.wr(8'h91, 8'h05);
		i_tmc_core_model.wr(8'h94, 8'h00);
		pulse8(1'b0, 3);
		suspend = 1'b1;
		pulse8(1'b0, 2);
		suspend = 1'b0;
		check("ext8", count_low_byte, 8'h05);
		i_tmc_core_model.wr(8'h91, 8'h07);
		i_tmc_core_model.wr(8'h94, 8'h00);
		pulse8(1'b1, 4);
		check("lfo8", count_low_byte, 8'h04);
		low_byte_clock_select = 1'b1;
		high_byte_clock_select = 1'b1;
		i_tmc_core_model.wr(8'h91, 8'h28);
		i_tmc_core_model.wr(8'h95, 8'h40);
		i_tmc_core_model.wr(8'h94, 8'hF0);
		clks(40);
		check("split high", count_high_byte, 8'h40);
		rdc(8'h91, 8'h68);
		check("low irq", {7'h00, timer_irq}, 8'h01);
		// Split high byte on the shared alternate source, low byte on system clock
		high_byte_clock_select = 1'b0;
		i_tmc_core_model.wr(8'h91, 8'h0D);
		i_tmc_core_model.wr(8'h95, 8'h00);
		pulse8(1'b0, 2);
		check("split alt", count_high_byte, 8'h02);
		give_verdict;
	end
endmodule
